// File: hdl/crrb_defines.svh
// Register map, field positions, reset values and timing counts of the CEC control block
`ifndef CRRB_DEFINES_SVH
`define CRRB_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRRB_OFF_UNIT_ENABLE   8'h00
`define CRRB_OFF_SOFT_RESET    8'h08
`define CRRB_OFF_RX_ENABLE     8'h0C
`define CRRB_OFF_RX_BUFFER     8'h10
`define CRRB_OFF_RX_SETUP_ONE  8'h14
`define CRRB_OFF_RX_SETUP_TWO  8'h18
`define CRRB_OFF_RX_SETUP_THR  8'h1C
`define CRRB_OFF_IRQ_STATUS    8'h34
`define CRRB_OFF_IRQ_MASK      8'h38

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define CRRB_BIT_SOFT_RESET    0
`define CRRB_BIT_RX_ENABLE     0
`define CRRB_BIT_UNIT_RUN      0
`define CRRB_BIT_UNIT_IDLE     1
`define CRRB_UNIT_EN_W         2
`define CRRB_BIT_IRQ_RX_BYTE   0
`define CRRB_IRQ_W             1
`define CRRB_RX_WORD_W         10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CRRB_RST_UNIT_ENABLE   2'h0
`define CRRB_RST_RX_ENABLE     1'h0
`define CRRB_RST_RX_BUFFER     10'h000
`define CRRB_RST_RX_SETUP      32'h0000_0000
`define CRRB_RST_IRQ           1'h0

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CRRB_RX_SYNC_STAGES    2

`endif

// File: hdl/crrb_pkg.sv
// Types shared by the CEC control block and its bench
package crrb_pkg;

    // One received byte with its trailing flags, laid out as in the buffer register
    typedef struct packed {
        logic       received_ack_flag;
        logic       received_end_of_message_flag;
        logic [7:0] received_byte;
    } crrb_rx_word_t;

    // Bus handshake phase of the register slave
    typedef enum logic {
        CRRB_BUS_IDLE,
        CRRB_BUS_ACK
    } crrb_bus_state_t;

endpackage

// File: hdl/crrb_top.sv
// CEC soft reset, receive enable and receive buffer control block
//
// Contract
// [RQ1] Writing 1 to soft reset bit 0 halts everything; writing 0 does nothing. Here the write of 1 is ignored while unit enable bit 0 is clear.
// [RQ2] Soft reset stops reception at once and drops any received data.
// [RQ3] Soft reset stops transmission at once and releases the bus line.
// [RQ4] Soft reset clears every register except the unit enable register.
// [RQ5] Writing receive enable 1 arms the receiver; writing 0 disables reception.
// [RQ6] Receive enable reads back the real receiver state, not the written value.
// [RQ7] Software programs all three receive setup registers before enabling reception.
// [RQ8] Receive enable reaches the receiver after a short synchronisation delay.
// [RQ9] Software stops transmit and receive before changing configuration.
// [RQ10] Buffer bits 7-0 hold the last received byte, bit 7 is MSB.
// [RQ11] Buffer bit 8 holds the end-of-message bit of that byte.
// [RQ12] Buffer bit 9 holds the acknowledge bit of that byte.
// [RQ13] Writes to the receive buffer are ignored and leave it unchanged.
// [RQ14] Software reads the buffer promptly after each receive interrupt.
// [RQ15] Clearing the unit enable keeps every register setting.
// [RQ16] Unused bits read zero; the soft reset bit always reads zero.
// [RQ17] Buffer fields update together when the receive interrupt is raised.
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "crrb_defines.svh"

module crrb_top #(
    parameter int ADDR_W      = 8,                      // Byte address width
    parameter int SYNC_STAGES = `CRRB_RX_SYNC_STAGES    // Receive enable sync depth
) (
    input  wire logic                   core_clk,         // 10 MHz core clock
    input  wire logic                   nrst,             // Synchronous reset, low
    input  wire logic                   ce,               // Clock enable, freezes all
    input  wire logic [ADDR_W-1:0]      avs_address,      // Byte address
    input  wire logic                   avs_read,         // Read request
    input  wire logic                   avs_write,        // Write request
    input  wire logic [31:0]            avs_writedata,    // Write data
    output logic      [31:0]            avs_readdata,     // Read data
    output logic                        avs_waitrequest,  // Stall while high
    input  wire crrb_pkg::crrb_rx_word_t rx_word,         // Byte from receive circuit
    input  wire logic                   rx_word_valid,    // Byte complete pulse
    input  wire logic                   tx_drive,         // Transmitter pulls line low
    input  wire logic                   line_i,           // Bus line level
    output logic                        line_o,           // Bus line drive value
    output logic                        line_oe,          // Bus line drive enable
    output logic                        rx_line,          // Sampled line to receiver
    output logic                        rx_arm,           // Receiver armed
    output logic                        rx_abort,         // Receiver abort pulse
    output logic                        tx_abort,         // Transmitter abort pulse
    output logic                        unit_run,         // Unit enable to the block
    output logic                        unit_idle_run,    // Keep running in idle mode
    output logic      [31:0]            rx_setup_one,     // Receive setup one
    output logic      [31:0]            rx_setup_two,     // Receive setup two
    output logic      [31:0]            rx_setup_three,   // Receive setup three
    output logic                        irq               // Receive interrupt, level
);
    import crrb_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 6 and 32");
    end
    if (SYNC_STAGES < 1 || SYNC_STAGES > 8) begin : g_bad_sync
        $error("SYNC_STAGES must lie between 1 and 8");
    end

    // ----------------------------------------------------------------
    // Address decode helper
    // ----------------------------------------------------------------
    // Word aligned match; low two address bits are ignored
    function automatic logic reg_sel(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        off);
        logic [ADDR_W-1:0] full_off;
        full_off = ADDR_W'(off);
        reg_sel  = (addr[ADDR_W-1:2] == full_off[ADDR_W-1:2]);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    crrb_bus_state_t                  bus_state_reg;
    logic [`CRRB_UNIT_EN_W-1:0]       unit_en_reg;
    logic                             rx_en_reg;
    logic [SYNC_STAGES-1:0]           rx_sync_reg;
    crrb_rx_word_t                    rx_buf_reg;
    logic [31:0]                      setup_reg [3];
    logic [`CRRB_IRQ_W-1:0]           irq_stat_reg;
    logic [`CRRB_IRQ_W-1:0]           irq_mask_reg;
    logic [`CRRB_IRQ_W-1:0]           irq_stat_next;
    logic [31:0]                      rd_mux;

    // ----------------------------------------------------------------
    // Bus handshake and address decode
    // ----------------------------------------------------------------
    // One wait state: request seen in IDLE, taken at the ACK edge
    wire bus_req    = avs_read | avs_write;
    wire bus_take   = (bus_state_reg == CRRB_BUS_ACK) & bus_req;
    wire wr_take    = bus_take & avs_write;
    wire rd_take    = bus_take & avs_read;
    wire unit_on    = unit_en_reg[`CRRB_BIT_UNIT_RUN];

    wire sel_unit   = reg_sel(avs_address, `CRRB_OFF_UNIT_ENABLE);
    wire sel_sreset = reg_sel(avs_address, `CRRB_OFF_SOFT_RESET);
    wire sel_rxen   = reg_sel(avs_address, `CRRB_OFF_RX_ENABLE);
    wire sel_rxbuf  = reg_sel(avs_address, `CRRB_OFF_RX_BUFFER);
    wire sel_su1    = reg_sel(avs_address, `CRRB_OFF_RX_SETUP_ONE);
    wire sel_su2    = reg_sel(avs_address, `CRRB_OFF_RX_SETUP_TWO);
    wire sel_su3    = reg_sel(avs_address, `CRRB_OFF_RX_SETUP_THR);
    wire sel_stat   = reg_sel(avs_address, `CRRB_OFF_IRQ_STATUS);
    wire sel_mask   = reg_sel(avs_address, `CRRB_OFF_IRQ_MASK);

    // With the unit off only the enable register accepts writes, so the rest keeps its value
    wire wr_live    = wr_take & unit_on; // RQ15

    // Self-clearing: the trigger is a strobe, nothing is stored
    wire soft_rst   = wr_live & sel_sreset & avs_writedata[`CRRB_BIT_SOFT_RESET]; // RQ1

    // Receive buffer has no write path at all
    wire wr_rxen    = wr_live & sel_rxen & ~soft_rst; // RQ5 RQ13
    wire wr_mask    = wr_live & sel_mask;
    wire [2:0] wr_setup = {wr_live & sel_su3, wr_live & sel_su2, wr_live & sel_su1};
    wire rd_stat    = rd_take & sel_stat;

    // A byte is only accepted while the receiver really runs
    wire rx_capture = rx_word_valid & rx_sync_reg[SYNC_STAGES-1] & unit_on & ~soft_rst; // RQ2

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    // Unused bits and unmapped offsets read zero; trigger reads zero
    always_comb begin
        rd_mux = 32'h0000_0000; // RQ16
        if (sel_unit) begin
            rd_mux[`CRRB_UNIT_EN_W-1:0] = unit_en_reg;
        end else if (sel_rxen) begin
            rd_mux[`CRRB_BIT_RX_ENABLE] = rx_sync_reg[SYNC_STAGES-1]; // RQ6
        end else if (sel_rxbuf) begin
            rd_mux[`CRRB_RX_WORD_W-1:0] = rx_buf_reg; // RQ10 RQ11 RQ12
        end else if (sel_su1) begin
            rd_mux = setup_reg[0];
        end else if (sel_su2) begin
            rd_mux = setup_reg[1];
        end else if (sel_su3) begin
            rd_mux = setup_reg[2];
        end else if (sel_stat) begin
            rd_mux[`CRRB_IRQ_W-1:0] = irq_stat_reg;
        end else if (sel_mask) begin
            rd_mux[`CRRB_IRQ_W-1:0] = irq_mask_reg;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status next value
    // ----------------------------------------------------------------
    // Set beats the read clear, so a byte landing during the read is kept
    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (rd_stat) begin
            irq_stat_next = '0;
        end
        if (rx_capture) begin
            irq_stat_next[`CRRB_BIT_IRQ_RX_BYTE] = 1'b1;
        end
        if (soft_rst) begin
            irq_stat_next = `CRRB_RST_IRQ; // RQ4
        end
    end

    // ----------------------------------------------------------------
    // Bus slave handshake
    // ----------------------------------------------------------------
    // Waitrequest rests high; it drops for exactly one cycle per access
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bus_state_reg   <= CRRB_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (ce) begin
            if (bus_state_reg == CRRB_BUS_IDLE && bus_req) begin
                bus_state_reg   <= CRRB_BUS_ACK;
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
            end else begin
                bus_state_reg   <= CRRB_BUS_IDLE;
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Unit enable register
    // ----------------------------------------------------------------
    // Untouched by soft reset; only the pin reset clears it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            unit_en_reg <= `CRRB_RST_UNIT_ENABLE;
        end else if (ce && wr_take && sel_unit) begin
            unit_en_reg <= avs_writedata[`CRRB_UNIT_EN_W-1:0]; // RQ4
        end
    end

    // ----------------------------------------------------------------
    // Receive enable and its synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst || (ce && soft_rst)) begin
            rx_en_reg <= `CRRB_RST_RX_ENABLE; // RQ4
        end else if (ce && wr_rxen) begin
            rx_en_reg <= avs_writedata[`CRRB_BIT_RX_ENABLE]; // RQ5
        end
    end

    // The chain stalls with the unit off, so the receiver keeps its state
    always_ff @(posedge core_clk) begin
        if (!nrst || (ce && soft_rst)) begin
            rx_sync_reg <= '0; // RQ2
        end else if (ce && unit_on) begin
            rx_sync_reg <= SYNC_STAGES'({rx_sync_reg, rx_en_reg}); // RQ8
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer
    // ----------------------------------------------------------------
    // Whole word in one edge, same edge as the status bit
    always_ff @(posedge core_clk) begin
        if (!nrst || (ce && soft_rst)) begin
            rx_buf_reg <= `CRRB_RST_RX_BUFFER; // RQ2 RQ4
        end else if (ce && rx_capture) begin
            rx_buf_reg <= rx_word; // RQ10 RQ11 RQ12 RQ17
        end
    end

    // ----------------------------------------------------------------
    // Receive setup registers
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 3; i++) begin : g_setup
        always_ff @(posedge core_clk) begin
            if (!nrst || (ce && soft_rst)) begin
                setup_reg[i] <= `CRRB_RST_RX_SETUP; // RQ4
            end else if (ce && wr_setup[i]) begin
                setup_reg[i] <= avs_writedata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, mask and output
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_stat_reg <= `CRRB_RST_IRQ;
            irq_mask_reg <= `CRRB_RST_IRQ;
            irq          <= 1'b0;
        end else if (ce) begin
            irq_stat_reg <= irq_stat_next;
            if (soft_rst) begin
                irq_mask_reg <= `CRRB_RST_IRQ; // RQ4
            end else if (wr_mask) begin
                irq_mask_reg <= avs_writedata[`CRRB_IRQ_W-1:0];
            end
            // Built from next values so irq rises with the buffer update
            irq <= |(irq_stat_next & (soft_rst ? `CRRB_RST_IRQ :
                     (wr_mask ? avs_writedata[`CRRB_IRQ_W-1:0] : irq_mask_reg))); // RQ17
        end
    end

    // ----------------------------------------------------------------
    // Abort strobes and line drive
    // ----------------------------------------------------------------
    // Open drain: only ever drives low, released the edge after soft reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_abort <= 1'b0;
            tx_abort <= 1'b0;
            line_oe  <= 1'b0;
            line_o   <= 1'b0;
            rx_line  <= 1'b1;
        end else if (ce) begin
            rx_abort <= soft_rst; // RQ2
            tx_abort <= soft_rst; // RQ3
            line_oe  <= tx_drive & unit_on & ~soft_rst; // RQ3
            line_o   <= 1'b0;
            rx_line  <= line_i;
        end
    end

    // ----------------------------------------------------------------
    // Register-fed outputs
    // ----------------------------------------------------------------
    assign rx_arm         = rx_sync_reg[SYNC_STAGES-1];
    assign unit_run       = unit_en_reg[`CRRB_BIT_UNIT_RUN];
    assign unit_idle_run  = unit_en_reg[`CRRB_BIT_UNIT_IDLE];
    assign rx_setup_one   = setup_reg[0];
    assign rx_setup_two   = setup_reg[1];
    assign rx_setup_three = setup_reg[2];

endmodule

`default_nettype wire

// File: bench/crrb_props.sv
// Port checker of the CEC control block, bound into its top module
`timescale 1ns/1ns
`default_nettype none
`include "crrb_defines.svh"
module crrb_props #(
    parameter int ADDR_W = 8  // Byte address width
) (
    input wire logic              core_clk,        // Core clock
    input wire logic              nrst,            // Reset, low
    input wire logic [ADDR_W-1:0] avs_address,     // Byte address
    input wire logic              avs_read,        // Read request
    input wire logic              avs_write,       // Write request
    input wire logic [31:0]       avs_writedata,   // Write data
    input wire logic [31:0]       avs_readdata,    // Read data
    input wire logic              avs_waitrequest, // Stall
    input wire logic              rx_word_valid,   // Byte pulse
    input wire logic              line_oe,         // Line drive enable
    input wire logic              rx_arm,          // Receiver armed
    input wire logic              rx_abort,        // Receive abort
    input wire logic              tx_abort,        // Transmit abort
    input wire logic              unit_run,        // Unit enable
    input wire logic [31:0]       rx_setup_one,    // Setup one
    input wire logic [31:0]       rx_setup_two,    // Setup two
    input wire logic [31:0]       rx_setup_three,  // Setup three
    input wire logic              irq              // Interrupt
);
    // ----------------------------------------------------------------
    // Decoded bus events
    // ----------------------------------------------------------------
    wire logic       wr_take = avs_write && !avs_waitrequest;
    wire logic       rd_take = avs_read && !avs_waitrequest;
    wire logic [7:0] off     = 8'(avs_address);
    wire logic       srst    = wr_take && off == `CRRB_OFF_SOFT_RESET && unit_run;
    wire logic       rxen_wr = wr_take && off == `CRRB_OFF_RX_ENABLE && unit_run;
    wire logic       mask_wr = wr_take && off == `CRRB_OFF_IRQ_MASK;
    logic            rxen_val;

    // Last value written to receive enable, the target of the sync stages
    always_ff @(posedge core_clk) begin
        if (rxen_wr) begin
            rxen_val <= avs_writedata[0];
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    AST_WAIT_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_SRST_ABORT: assert property (srst && avs_writedata[0] |-> ##[1:2] rx_abort && tx_abort)
        else $error("soft reset gave no abort pulses");
    AST_SRST_LINE: assert property (srst && avs_writedata[0] |=> !line_oe)
        else $error("line still driven after soft reset");
    AST_SRST_CLEAR: assert property (srst && avs_writedata[0] |=> rx_setup_one == 32'h0 &&
        rx_setup_two == 32'h0 && rx_setup_three == 32'h0 && !irq && unit_run)
        else $error("soft reset left registers set or cleared unit enable");
    AST_SRST_NOP: assert property (srst && !avs_writedata[0] |=> !rx_abort && $stable(rx_setup_one))
        else $error("writing zero to soft reset had an effect");
    AST_RXEN_SYNC: assert property (rxen_wr |=> ##[0:3] rx_arm == rxen_val)
        else $error("receiver state did not follow receive enable");
    AST_RD_SRST_ZERO: assert property (rd_take && off == `CRRB_OFF_SOFT_RESET |-> avs_readdata == 32'h0)
        else $error("soft reset register read nonzero");
    AST_RD_UPPER_ZERO: assert property (rd_take && off == `CRRB_OFF_RX_BUFFER |-> avs_readdata[31:10] == 22'h0)
        else $error("buffer unused bits read nonzero");
    AST_UNIT_KEEP: assert property ($fell(unit_run) |-> $stable(rx_setup_one) && $stable(rx_setup_three))
        else $error("unit disable changed a setting");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(rx_word_valid) || $past(mask_wr) || $past(mask_wr, 2))
        else $error("interrupt rose without a byte or mask write");
endmodule
bind crrb_top crrb_props #(.ADDR_W(ADDR_W)) u_props (.core_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_word_valid, .line_oe, .rx_arm,
    .rx_abort, .tx_abort, .unit_run, .rx_setup_one, .rx_setup_two, .rx_setup_three, .irq);
`default_nettype wire

// File: bench/crrb_node_model.sv
// Model of another node on the shared open-drain bus line
`timescale 1ns/1ns
`default_nettype none
module crrb_node_model (
    input  wire logic line_o,    // Device drive value
    input  wire logic line_oe,   // Device drive enable
    input  wire logic hold_low,  // This node pulls low
    output logic      line_lvl   // Resolved line level
);
    // Wired-AND with pull-up, so a released line reads high, never the last value
    assign line_lvl = !((line_oe && !line_o) || hold_low);
endmodule
`default_nettype wire

// File: bench/tb_cec_reset_rx_enable_buffer.sv
// Self-checking bench of the CEC control block
`timescale 1ns/1ns
`default_nettype none
module tb_cec_reset_rx_enable_buffer;
    import crrb_pkg::*;
    logic          core_clk = 1'b0, nrst = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]    avs_address = 8'h00;
    logic [31:0]   avs_writedata = 32'h0, avs_readdata, rx_setup_one, rx_setup_two, rx_setup_three;
    crrb_rx_word_t rx_word = '0;
    logic          rx_word_valid = 1'b0, tx_drive = 1'b0, hold_low = 1'b0, line_i, both_abort = 1'b0;
    logic          avs_waitrequest, line_o, line_oe, rx_line, rx_arm, rx_abort, tx_abort, unit_run;
    logic          unit_idle_run, irq;
    logic [9:0]    words [3] = '{10'h2A5, 10'h15A, 10'h080};
    int            n_errors = 0, checks = 0, cycles = 0;

    crrb_top DUT (.core_clk, .nrst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .rx_word, .rx_word_valid, .tx_drive, .line_i, .line_o,
        .line_oe, .rx_line, .rx_arm, .rx_abort, .tx_abort, .unit_run, .unit_idle_run,
        .rx_setup_one, .rx_setup_two, .rx_setup_three, .irq);
    crrb_node_model u_node (.line_o, .line_oe, .hold_low, .line_lvl(line_i));

    // ----------------------------------------------------------------
    // Clock, watchdog and abort monitor
    // ----------------------------------------------------------------
    always #50 core_clk = ~core_clk;
    // Both aborts must pulse together; latched so a one-cycle pulse is not missed
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (rx_abort === 1'b1 && tx_abort === 1'b1) begin
            both_abort <= 1'b1;
        end
        if (cycles == 5000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until the edge that samples waitrequest low; data taken there
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus_xfer(1'b0, a, 32'h0, q);
        check_word(q, exp);
    endtask
    task automatic send_byte(input logic [9:0] w);
        @(posedge core_clk);
        rx_word <= w;
        rx_word_valid <= 1'b1;
        @(posedge core_clk);
        rx_word_valid <= 1'b0;
        @(negedge core_clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h40, 32'h0);
        check_word({irq, line_oe}, 32'h0);
    endtask
    task automatic t_unit_keep();
        wr(8'h00, 32'h3);
        wr(8'h14, 32'h1234_5678);
        wr(8'h18, 32'h0F0F_0F0F);
        wr(8'h1C, 32'hC0DE_0003);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'hFFFF_FFFF);
        rd_chk(8'h14, 32'h1234_5678);
        rd_chk(8'h1C, 32'hC0DE_0003);
        wr(8'h00, 32'h3);
        @(negedge core_clk);
        check_word(unit_idle_run, 32'h1);
    endtask
    task automatic t_rx_enable();
        send_byte(10'h3FF);
        rd_chk(8'h10, 32'h0);
        wr(8'h0C, 32'h1);
        repeat (3) @(posedge core_clk);
        rd_chk(8'h0C, 32'h1);
        wr(8'h0C, 32'h0);
        repeat (3) @(posedge core_clk);
        rd_chk(8'h0C, 32'h0);
        send_byte(10'h3FF);
        rd_chk(8'h10, 32'h0);
    endtask
    task automatic t_rx_buffer();
        wr(8'h38, 32'h1);
        wr(8'h0C, 32'h1);
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            send_byte(words[i]);
            check_word(irq, 32'h1);
            rd_chk(8'h10, {22'h0, words[i]});
            rd_chk(8'h34, 32'h1);
            rd_chk(8'h34, 32'h0);
            @(negedge core_clk);
            check_word(irq, 32'h0);
        end
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h080);
        wr(8'h38, 32'h0);
        send_byte(10'h2A5);
        check_word(irq, 32'h0);
        wr(8'h38, 32'h1);
        repeat (2) @(negedge core_clk);
        check_word(irq, 32'h1);
    endtask
    task automatic t_soft_reset();
        wr(8'h08, 32'h0);
        rd_chk(8'h14, 32'h1234_5678);
        rd_chk(8'h10, 32'h2A5);
        @(posedge core_clk);
        tx_drive <= 1'b1;
        repeat (2) @(negedge core_clk);
        check_word({line_oe, line_i}, 32'h2);
        wr(8'h08, 32'h1);
        tx_drive <= 1'b0;
        @(negedge core_clk);
        check_word({line_oe, line_i}, 32'h1);
        @(negedge core_clk);
        check_word(both_abort, 32'h1);
        rd_chk(8'h10, 32'h0);
        rd_chk(8'h14, 32'h0);
        rd_chk(8'h38, 32'h0);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h00, 32'h3);
        check_word(irq, 32'h0);
    endtask
    task automatic t_line_sample();
        @(posedge core_clk);
        hold_low <= 1'b1;
        repeat (2) @(negedge core_clk);
        check_word(rx_line, 32'h0);
        hold_low <= 1'b0;
        repeat (2) @(negedge core_clk);
        check_word(rx_line, 32'h1);
    endtask

    task automatic final_report();
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Reset for four cycles, then the scenarios in order
    initial begin
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset_values();
        t_unit_keep();
        t_rx_enable();
        t_rx_buffer();
        t_soft_reset();
        t_line_sample();
        final_report();
    end
endmodule
`default_nettype wire
